// File: core/pdip_pkg.sv
// Purpose: shared constants and types for the parallel DMA input port
// Assumes: 32-bit register port, one aligned word per register
// Notes: offsets are byte addresses
package pdip_pkg;

  localparam int unsigned PDIP_WORD_W = 16;
  localparam int unsigned PDIP_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] PDIP_OFS_CTRL = 8'h00;
  localparam logic [7:0] PDIP_OFS_PULSE = 8'h04;
  localparam logic [7:0] PDIP_OFS_STATUS = 8'h08;
  localparam logic [7:0] PDIP_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] PDIP_OFS_DATA = 8'h10;
  localparam logic [7:0] PDIP_OFS_DELAY = 8'h14;

  // control register fields
  localparam int unsigned PDIP_CTL_INPUT_DIRECTION_BIT = 0;
  localparam int unsigned PDIP_CTL_FALL = 1;
  localparam int unsigned PDIP_CTL_HOLDB = 2;
  localparam int unsigned PDIP_CTL_ACKLOW = 3;
  localparam int unsigned PDIP_CTL_ATTM = 4;

  // pulse register fields
  localparam int unsigned PDIP_PLS_START = 0;
  localparam int unsigned PDIP_PLS_SETIDLE = 1;
  localparam int unsigned PDIP_PLS_MASTER_CLEAR_PULSE = 2;

  // status register fields
  localparam int unsigned PDIP_ST_IDLE = 0;
  localparam int unsigned PDIP_ST_ACK = 1;
  localparam int unsigned PDIP_ST_ATTN = 2;

  // flags register fields
  localparam int unsigned PDIP_FL_PARITY_ERROR_FLAG = 0;
  localparam int unsigned PDIP_FL_HALT = 1;
  localparam int unsigned PDIP_FL_SENSE = 2;
  localparam int unsigned PDIP_FL_LOWADR = 5;

  localparam logic [7:0] PDIP_DELAY_RST = 8'h04;
  localparam logic [4:0] PDIP_CTRL_RST = 5'h00;

  typedef struct packed {
    logic [PDIP_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdip_req_t;

  typedef struct packed {
    logic [PDIP_WORD_W-1:0] word;
    logic parity;
  } pdip_in_word_t;

  typedef struct packed {
    logic [PDIP_WORD_W-1:0] word;
    logic valid;
  } pdip_push_t;

endpackage : pdip_pkg

// File: core/pdip_port.sv
// Purpose: device-side input handshake of a 16-bit parallel DMA port
// Assumes: core_clk 100 MHz, rst_n async active low, external inputs asynchronous
// Notes: fifo drain state comes from the DMA side as fifo_empty
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pdip_port
  import pdip_pkg::*;
#(
  parameter int unsigned DELAY_W = 8
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pdip_pkg::pdip_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire pdip_pkg::pdip_in_word_t input_word_lines,
  input wire logic transfer_request_first,
  input wire logic transfer_request_second,
  input wire logic attention_input,
  input wire logic [2:0] user_sense_inputs,
  input wire logic low_address_input,
  input wire logic byte_select_input,
  input wire logic direction_input,
  input wire logic count_step_enable_input,
  input wire logic pointer_step_enable_input,
  input wire logic bus_hold_request_input,
  input wire logic range_underflow,
  input wire logic fifo_empty,
  output pdip_pkg::pdip_push_t fifo_push,
  output logic ack_output,
  output logic idle_output,
  output logic irq
);
  import pdip_pkg::*;

  // the counter and the register field cannot serve other widths
  if (DELAY_W < 1 || DELAY_W > 8)
  begin : g_bad_delay_w
    $error("pdip_port: DELAY_W must be 1..8");
  end

  typedef enum logic [2:0] {
    PDIP_S_IDLE = 3'b001,
    PDIP_S_WAIT = 3'b010,
    PDIP_S_DROP = 3'b100
  } pdip_state_t;

  typedef struct packed {
    logic [2:0] sa;
    logic [2:0] sb;
    logic [2:0] sat;
    logic [2:0] sl;
    logic [2:0] su0;
    logic [2:0] su1;
    logic [2:0] su2;
    logic a_q;
    logic b_q;
    logic att_q;
    logic low_q;
    logic [2:0] sense_q;
    pdip_state_t st;
    logic [DELAY_W-1:0] cnt;
    logic [4:0] ctrl;
    logic [DELAY_W-1:0] delay;
    logic idle;
    logic halt;
    logic parity_error_flag;
    logic [15:0] data;
    pdip_push_t push;
    logic ack_pin;
    logic irq;
    logic [31:0] rdata;
  } pdip_regs_t;

  pdip_regs_t r_q;
  pdip_regs_t r_d;

  // three-stage sync; value counts once stages two and three agree
  function automatic logic [2:0] sync3(input logic [2:0] s, input logic pin);
    sync3 = {s[1:0], pin};
  endfunction : sync3

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[1] : prev;
  endfunction : filt

  ////////////////////////////////////////////////////////////////////////
  logic a_n, b_n, att_n, low_n, a_rise, b_rise, req, start_p, setidle_p, master_clear_pulse_p, ack_on;
  logic fall, a_lvl, b_lvl;
  logic [2:0] sense_n;

  always_comb
  begin
    r_d = r_q;
    // first stage feeds only the second
    r_d.sa = sync3(r_q.sa, transfer_request_first);
    r_d.sb = sync3(r_q.sb, transfer_request_second);
    r_d.sat = sync3(r_q.sat, attention_input);
    r_d.sl = sync3(r_q.sl, low_address_input);
    r_d.su0 = sync3(r_q.su0, user_sense_inputs[0]);
    r_d.su1 = sync3(r_q.su1, user_sense_inputs[1]);
    r_d.su2 = sync3(r_q.su2, user_sense_inputs[2]);
    fall = r_q.ctrl[PDIP_CTL_FALL];
    a_n = filt(r_q.sa, r_q.a_q);
    b_n = filt(r_q.sb, r_q.b_q);
    att_n = filt(r_q.sat, r_q.att_q);
    low_n = filt(r_q.sl, r_q.low_q);
    sense_n = {filt(r_q.su2, r_q.sense_q[2]), filt(r_q.su1, r_q.sense_q[1]), filt(r_q.su0, r_q.sense_q[0])};
    r_d.a_q = a_n;
    r_d.b_q = b_n;
    r_d.att_q = att_n;
    r_d.low_q = low_n;
    r_d.sense_q = sense_n;
    // edges judged on raw levels, so a polarity write cannot fake an edge
    a_rise = fall ? (r_q.a_q & ~a_n) : (a_n & ~r_q.a_q);
    b_rise = fall ? (r_q.b_q & ~b_n) : (b_n & ~r_q.b_q);
    a_lvl = a_n ^ fall;
    b_lvl = b_n ^ fall;
    if (r_q.ctrl[PDIP_CTL_HOLDB])
    begin
      b_rise = 1'b0;
      b_lvl = 1'b0;
    end
    // lone edge with other low, or both edges together
    req = (a_rise & ~b_lvl) | (b_rise & ~a_lvl) | (a_rise & b_rise);

    start_p = bus_req.wr && bus_req.addr == PDIP_OFS_PULSE && bus_req.wdata[PDIP_PLS_START];
    setidle_p = bus_req.wr && bus_req.addr == PDIP_OFS_PULSE && bus_req.wdata[PDIP_PLS_SETIDLE];
    master_clear_pulse_p = bus_req.wr && bus_req.addr == PDIP_OFS_PULSE && bus_req.wdata[PDIP_PLS_MASTER_CLEAR_PULSE];

    if (bus_req.wr && bus_req.addr == PDIP_OFS_CTRL)
      r_d.ctrl = bus_req.wdata[4:0];
    if (bus_req.wr && bus_req.addr == PDIP_OFS_DELAY)
      r_d.delay = bus_req.wdata[DELAY_W-1:0];

    // start needs attention low at the pulse itself; no later retry
    if (start_p && !att_n)
      r_d.idle = 1'b0;
    if (setidle_p || master_clear_pulse_p || range_underflow)
      r_d.idle = 1'b1;
    if (att_n)
    begin
      r_d.idle = 1'b1;
      r_d.halt = 1'b1;
    end

    r_d.push.valid = 1'b0;
    case (r_q.st)
      PDIP_S_IDLE:
      begin
        // inputs byte_select, direction, step enables and bus hold never gate this
        if (req && !r_q.idle)
        begin
          r_d.st = PDIP_S_WAIT;
          r_d.cnt = r_q.delay;
        end
      end
      PDIP_S_WAIT:
      begin
        if (r_q.cnt == '0)
        begin
          r_d.data = input_word_lines.word;
          if (~^{input_word_lines.word, input_word_lines.parity})
            r_d.parity_error_flag = 1'b1;
          r_d.push.word = input_word_lines.word;
          r_d.push.valid = r_q.ctrl[PDIP_CTL_INPUT_DIRECTION_BIT];
          r_d.st = PDIP_S_DROP;
        end
        else
          r_d.cnt = r_q.cnt - 1'b1;
      end
      PDIP_S_DROP:
        r_d.st = PDIP_S_IDLE;
      default:
        r_d.st = PDIP_S_IDLE;
    endcase
    if (master_clear_pulse_p)
      r_d.st = PDIP_S_IDLE;

    ack_on = (r_d.st == PDIP_S_WAIT);
    r_d.ack_pin = ack_on ^ r_d.ctrl[PDIP_CTL_ACKLOW];

    // halt and parity flags clear on read; a set in the same cycle wins
    if (bus_req.rd && bus_req.addr == PDIP_OFS_FLAGS)
    begin
      if (!att_n)
        r_d.halt = 1'b0;
      if (!(r_q.st == PDIP_S_WAIT && r_q.cnt == '0 && ~^{input_word_lines.word, input_word_lines.parity}))
        r_d.parity_error_flag = 1'b0;
    end
    if (master_clear_pulse_p)
    begin
      r_d.halt = att_n;
      r_d.parity_error_flag = 1'b0;
    end

    r_d.irq = r_q.halt && r_q.ctrl[PDIP_CTL_ATTM] && (!r_q.ctrl[PDIP_CTL_INPUT_DIRECTION_BIT] || fifo_empty);

    r_d.rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        PDIP_OFS_CTRL: r_d.rdata = {27'h0, r_q.ctrl};
        PDIP_OFS_STATUS: r_d.rdata = {29'h0, r_q.att_q, r_q.st == PDIP_S_WAIT, r_q.idle};
        PDIP_OFS_FLAGS: r_d.rdata = {26'h0, r_q.low_q, r_q.sense_q, r_q.halt, r_q.parity_error_flag};
        PDIP_OFS_DATA: r_d.rdata = {16'h0, r_q.data};
        PDIP_OFS_DELAY: r_d.rdata = {{(32-DELAY_W){1'b0}}, r_q.delay};
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
      r_q.st <= PDIP_S_IDLE;
      r_q.idle <= 1'b1;
      r_q.ctrl <= PDIP_CTRL_RST;
      r_q.delay <= PDIP_DELAY_RST[DELAY_W-1:0];
    end
    else
      r_q <= r_d;
  end

  assign bus_rdata = r_q.rdata;
  assign fifo_push = r_q.push;
  assign ack_output = r_q.ack_pin;
  assign idle_output = r_q.idle;
  assign irq = r_q.irq;

endmodule : pdip_port
`default_nettype wire

// File: verification/pdip_far_model.sv
// Purpose: far-side word source for pdip_port
// Assumes: one word in flight at a time
// Notes: lines show the inverse once a word is done
`timescale 1ns/1ns
`default_nettype none
module pdip_far_model
  import pdip_pkg::*;
(
  input wire logic core_clk,
  input wire logic ack_output,
  input wire logic ack_low,
  output pdip_pkg::pdip_in_word_t input_word_lines,
  output logic transfer_request_first,
  output logic transfer_request_second
);
  initial
  begin
    input_word_lines = '0;
    transfer_request_first = 1'b0;
    transfer_request_second = 1'b0;
  end
  task automatic send(input logic [1:0] sel, input pdip_in_word_t v, input logic fall, output logic got);
    int n;
    input_word_lines <= v;
    @(posedge core_clk);
    transfer_request_first <= sel[0] ^ fall;
    transfer_request_second <= sel[1] ^ fall;
    got = 1'b0;
    for (n = 0; n < 20 && !got; n++)
    begin
      @(posedge core_clk);
      got = ack_output !== ack_low;
    end
    for (n = 0; n < 40 && ack_output !== ack_low; n++)
    begin
      @(posedge core_clk);
    end
    transfer_request_first <= fall;
    transfer_request_second <= fall;
    input_word_lines <= ~v;
    // lets the synchroniser and the dead cycle pass
    repeat (6) @(posedge core_clk);
  endtask : send
endmodule : pdip_far_model
`default_nettype wire

// File: verification/pdip_port_checker.sv
// Purpose: port-level checks of pdip_port
// Assumes: ack polarity changes only between words
// Notes: bound into every pdip_port
`timescale 1ns/1ns
`default_nettype none
module pdip_port_checker
  import pdip_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pdip_pkg::pdip_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic attention_input,
  input wire logic range_underflow,
  input wire pdip_pkg::pdip_push_t fifo_push,
  input wire logic ack_output,
  input wire logic idle_output,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its slot");
  a_push_pulse: assert property (fifo_push.valid |=> !fifo_push.valid)
    else $error("push longer than one cycle");
  a_push_ack_drop: assert property (fifo_push.valid |-> $changed(ack_output))
    else $error("ack not dropped with push");
  a_ack_held: assert property (fifo_push.valid |-> $past(ack_output, 2) == $past(ack_output))
    else $error("ack too short before capture");
  a_under_idle: assert property (range_underflow |=> idle_output)
    else $error("underflow did not set idle");
  a_attn_idle: assert property ($rose(attention_input) |-> ##[1:8] idle_output)
    else $error("attention did not set idle");
  a_irq_idle: assert property ($rose(irq) |-> idle_output)
    else $error("irq without idle");
  // flag clears by read or write land one cycle late on irq
  a_irq_level: assert property (irq && !bus_req.rd && !$past(bus_req.rd) && !bus_req.wr && !$past(bus_req.wr)
    |=> irq)
    else $error("irq dropped on its own");
  c_push: cover property (fifo_push.valid);
  c_irq: cover property ($rose(irq));
  c_under: cover property (range_underflow ##1 idle_output);
endmodule : pdip_port_checker
bind pdip_port pdip_port_checker i_pdip_port_checker (.core_clk, .rst_n, .bus_req, .bus_rdata,
  .attention_input, .range_underflow, .fifo_push, .ack_output, .idle_output, .irq);
`default_nettype wire

// File: verification/test_pdip_port.sv
// Purpose: self-checking bench of pdip_port
// Assumes: capture delay kept small, far model drives requests
// Notes: ignored control inputs held high to show they change nothing
`timescale 1ns/1ns
`default_nettype none
module test_pdip_port;
  import pdip_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pdip_req_t bus_req = '0;
  pdip_in_word_t lines;
  pdip_push_t fifo_push;
  logic [31:0] bus_rdata, v;
  logic rq_a, rq_b, ack_output, idle_output, irq, got;
  logic ackl = 1'b0, attn = 1'b0, under = 1'b0, f_empty = 1'b1, lowa = 1'b1;
  logic [2:0] sense = 3'h5;
  logic [15:0] w = 16'h0;
  logic [15:0] pat [3] = '{16'h8001, 16'h7FFE, 16'hA5C3};
  int n_fail = 0, checks = 0, n;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (fifo_push.valid === 1'b1) w <= fifo_push.word;
  pdip_port i_pdip_port (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .input_word_lines(lines), .transfer_request_first(rq_a), .transfer_request_second(rq_b),
    .attention_input(attn), .user_sense_inputs(sense), .low_address_input(lowa), .byte_select_input(1'b1),
    .direction_input(1'b1), .count_step_enable_input(1'b1), .pointer_step_enable_input(1'b1),
    .bus_hold_request_input(1'b1), .range_underflow(under), .fifo_empty(f_empty), .fifo_push(fifo_push),
    .ack_output(ack_output), .idle_output(idle_output), .irq(irq));
  pdip_far_model i_pdip_far_model (.core_clk(core_clk), .ack_output(ack_output), .ack_low(ackl),
    .input_word_lines(lines), .transfer_request_first(rq_a), .transfer_request_second(rq_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus_req <= '0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) bus_req <= '0;
    #1 chk(bus_rdata, exp);
  endtask : rc
  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic xfer(input logic [1:0] sel, input logic [15:0] x, input logic p, input logic fall, input logic e);
    i_pdip_far_model.send(sel, '{x, p}, fall, got);
    chk(got, e);
  endtask : xfer
  task automatic conclude;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(1);
    chk(idle_output, 1'b1);
    rc(PDIP_OFS_DELAY, {24'h0, PDIP_DELAY_RST});
    rc(PDIP_OFS_CTRL, 32'h0);
    rc(PDIP_OFS_STATUS, 32'h1);
    wr(8'h20, 32'hFF);
    rc(8'h20, 32'h0);
    rc(PDIP_OFS_FLAGS, 32'h34);
    @(posedge core_clk) sense <= 3'h2;
    lowa <= 1'b0;
    settle(6);
    rc(PDIP_OFS_FLAGS, 32'h08);
    xfer(2'h1, 16'h1234, ~^16'h1234, 1'b0, 1'b0);
    wr(PDIP_OFS_CTRL, 32'h1);
    wr(PDIP_OFS_DELAY, 32'h2);
    wr(PDIP_OFS_PULSE, 32'h1);
    rc(PDIP_OFS_STATUS, 32'h0);
    for (n = 0; n < 3; n++)
    begin
      xfer(2'(n + 1), pat[n], ~^pat[n], 1'b0, 1'b1);
      chk(w, pat[n]);
      rc(PDIP_OFS_DATA, pat[n]);
    end
    xfer(2'h1, 16'h00F0, ^16'h00F0, 1'b0, 1'b1);
    chk(w, 16'h00F0);
    rc(PDIP_OFS_FLAGS, 32'h09);
    rc(PDIP_OFS_FLAGS, 32'h08);
    wr(PDIP_OFS_CTRL, 32'h0B);
    ackl = 1'b1;
    settle(2);
    chk(ack_output, 1'b1);
    xfer(2'h0, 16'h0, 1'b0, 1'b1, 1'b0);
    xfer(2'h1, 16'h5A5A, ~^16'h5A5A, 1'b1, 1'b1);
    chk(w, 16'h5A5A);
    wr(PDIP_OFS_CTRL, 32'h05);
    ackl = 1'b0;
    xfer(2'h0, 16'h0, 1'b0, 1'b0, 1'b0);
    xfer(2'h2, 16'h0F0F, ~^16'h0F0F, 1'b0, 1'b0);
    xfer(2'h1, 16'h0F0F, ~^16'h0F0F, 1'b0, 1'b1);
    // drain held off: irq must wait for the fifo
    wr(PDIP_OFS_CTRL, 32'h11);
    @(posedge core_clk) f_empty <= 1'b0;
    attn <= 1'b1;
    settle(10);
    chk(idle_output, 1'b1);
    chk(irq, 1'b0);
    wr(PDIP_OFS_PULSE, 32'h1);
    @(posedge core_clk) f_empty <= 1'b1;
    settle(3);
    chk(irq, 1'b1);
    @(posedge core_clk) attn <= 1'b0;
    settle(10);
    chk(idle_output, 1'b1);
    rc(PDIP_OFS_FLAGS, 32'h0A);
    settle(3);
    chk(irq, 1'b0);
    wr(PDIP_OFS_PULSE, 32'h1);
    settle(2);
    chk(idle_output, 1'b0);
    @(posedge core_clk) under <= 1'b1;
    @(posedge core_clk) under <= 1'b0;
    settle(1);
    chk(idle_output, 1'b1);
    wr(PDIP_OFS_PULSE, 32'h1);
    wr(PDIP_OFS_PULSE, 32'h2);
    settle(2);
    chk(idle_output, 1'b1);
    conclude();
  end
endmodule : test_pdip_port
`default_nettype wire
